/* bench/spsi_peer.sv */
// Behavioural model of the remote bridge port across the serial link.
`timescale 1ns/1ps
module spsi_peer (
  input wire i_ref_clk,
  output reg o_err_symbol,
  output reg o_link_up,
  output reg o_req_pending
);
  initial begin
    o_err_symbol = 1'b0;
    o_link_up = 1'b0;
    o_req_pending = 1'b0;
  end
  // The error symbol is held several cycles so that the receiver filter accepts it.
  task send_error;
    begin
      @(posedge i_ref_clk);
      o_err_symbol <= 1'b1;
      repeat (6) @(posedge i_ref_clk);
      o_err_symbol <= 1'b0;
    end
  endtask
  task set_lines(input up, input req);
    begin
      @(posedge i_ref_clk);
      o_link_up <= up;
      o_req_pending <= req;
    end
  endtask
endmodule

/* bench/spsi_port_status_irq_test.sv */
// Self-checking bench of the status flags and interrupt vector block.
`timescale 1ns/1ps
`include "spsi_defs.vh"
module spsi_port_status_irq_test;
  reg i_ref_clk = 1'b0;
  reg i_rstn = 1'b0;
  reg i_local_rx_error = 1'b0;
  reg i_slave_cmd_fifo_nonempty = 1'b0, i_slave_data_fifo_nonempty = 1'b0;
  reg i_master_cmd_fifo_nonempty = 1'b0, i_master_data_fifo_nonempty = 1'b0;
  reg i_slave_request_pending = 1'b0;
  reg [31:0] i_irq_event = 32'h0000_0000, i_wdata = 32'h0000_0000;
  reg [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
  reg i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
  reg [3:0] i_wstrb = 4'hf;
  wire i_remote_error_symbol, i_link_up, i_master_request_pending;
  wire o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_port_interrupt_out, o_irq;
  wire [1:0] o_bresp, o_rresp;
  wire [31:0] o_rdata;
  reg [33:0] expq[$];
  reg [15:0] rnd = 16'h9b19;
  reg [31:0] v, s;
  reg [1:0] bexp = 2'h0;
  integer err_total = 0, num_checks = 0, i, k, n;
  always #20 i_ref_clk = ~i_ref_clk;
  spsi_port_status_irq spsi_port_status_irq_inst (.*);
  spsi_peer spsi_peer_inst (.i_ref_clk(i_ref_clk), .o_err_symbol(i_remote_error_symbol),
    .o_link_up(i_link_up), .o_req_pending(i_master_request_pending));
  // ======
  // Helpers
  function [15:0] lfsr(input [15:0] x);
    lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task chk(input string nm, input [33:0] e, input [33:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("BAD %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // Ready for the answer is raised with the request and held until the answer is seen.
  task hs;
    begin
      n = 0;
      while (n < 40) begin
        @(posedge i_ref_clk);
        if (i_awvalid && o_awready) i_awvalid <= 1'b0;
        if (i_wvalid && o_wready) i_wvalid <= 1'b0;
        if (i_arvalid && o_arready) i_arvalid <= 1'b0;
        if (o_bvalid && i_bready) begin
          chk("bresp", {32'h0, bexp}, {32'h0, o_bresp});
          i_bready <= 1'b0;
          n = 99;
        end else if (o_rvalid && i_rready) begin
          i_rready <= 1'b0;
          n = 99;
        end else begin
          n = n + 1;
        end
      end
      if (n != 99) begin
        err_total = err_total + 1;
        $display("BAD bus exp answer got none");
        tally_and_finish;
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge i_ref_clk);
      i_awaddr <= a;
      i_wdata <= d;
      bexp = (a > 8'h13) ? `SPSI_RESP_SLVERR : `SPSI_RESP_OKAY;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      hs;
    end
  endtask
  task rd(input [7:0] a, input [33:0] e);
    begin
      expq.push_back(e);
      @(posedge i_ref_clk);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      hs;
    end
  endtask
  always @(posedge i_ref_clk) begin
    if (o_rvalid && i_rready) begin
      if (expq.size() == 0) chk("rdq", 34'h0, 34'h1);
      else chk("rdata", expq.pop_front(), {o_rresp, o_rdata});
    end
  end
  // ======
  // Scenarios
  initial begin
    repeat (20) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    rd(`SPSI_OFF_PRIVEC, 34'h0_8000_0000);
    rd(`SPSI_OFF_IRQSTAT, 34'h0);
    rd(8'h20, {`SPSI_RESP_SLVERR, 32'h0000_0000});
    wr(8'h20, 32'hffff_ffff);
    $display("test reset done");
    for (i = 0; i < 4; i = i + 1) begin
      rnd = lfsr(rnd);
      @(posedge i_ref_clk);
      {i_slave_cmd_fifo_nonempty, i_slave_data_fifo_nonempty, i_master_cmd_fifo_nonempty,
        i_master_data_fifo_nonempty} <= rnd[3:0];
      i_slave_request_pending <= rnd[4];
      spsi_peer_inst.set_lines(i[0], i[1]);
      repeat (8) @(posedge i_ref_clk);
      s = {25'h0, rnd[3:0], rnd[4], i[1], i[0]};
      rd(`SPSI_OFF_STATUS, {2'h0, s});
    end
    $display("test status done");
    spsi_peer_inst.send_error;
    i_local_rx_error <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    i_local_rx_error <= 1'b0;
    repeat (8) @(posedge i_ref_clk);
    rd(`SPSI_OFF_STATUS, {2'h0, s | 32'h0000_0180});
    chk("intr", 34'h0, {33'h0, o_port_interrupt_out});
    wr(`SPSI_OFF_CTRL, 32'h0000_2000);
    chk("intr", 34'h1, {33'h0, o_port_interrupt_out});
    wr(`SPSI_OFF_STATUS, 32'h0000_0000);
    rd(`SPSI_OFF_STATUS, {2'h0, s | 32'h0000_0180});
    wr(`SPSI_OFF_STATUS, 32'h0000_0100);
    rd(`SPSI_OFF_STATUS, {2'h0, s | 32'h0000_0080});
    chk("intr", 34'h1, {33'h0, o_port_interrupt_out});
    wr(`SPSI_OFF_STATUS, 32'h0000_0080);
    rd(`SPSI_OFF_STATUS, {2'h0, s});
    chk("intr", 34'h0, {33'h0, o_port_interrupt_out});
    $display("test errors done");
    rnd = lfsr(rnd);
    v = {rnd, lfsr(rnd)} | 32'h8000_0001;
    @(posedge i_ref_clk);
    i_irq_event <= v;
    @(posedge i_ref_clk);
    i_irq_event <= 32'h0000_0000;
    rd(`SPSI_OFF_IRQSTAT, {2'h0, v});
    chk("irq", 34'h0, {33'h0, o_irq});
    wr(`SPSI_OFF_IRQMASK, 32'hffff_ffff);
    chk("irq", 34'h1, {33'h0, o_irq});
    while (v != 32'h0000_0000) begin
      k = 0;
      while (!v[k]) k = k + 1;
      rd(`SPSI_OFF_PRIVEC, {29'h0, k[4:0]});
      wr(`SPSI_OFF_PRIVEC, 32'h7fff_ffe0 | k);
      v[k] = 1'b0;
    end
    rd(`SPSI_OFF_IRQSTAT, 34'h0);
    rd(`SPSI_OFF_PRIVEC, 34'h0_8000_0000);
    chk("irq", 34'h0, {33'h0, o_irq});
    $display("test vector done");
    tally_and_finish;
  end
endmodule

/* bench/spsi_props.sv */
// Checker of the register bus handshake and read results of the status block.
`timescale 1ns/1ps
`include "spsi_defs.vh"
module spsi_props (
  input wire i_ref_clk,
  input wire i_rstn,
  input wire [7:0] i_araddr,
  input wire i_awvalid,
  input wire o_awready,
  input wire i_wvalid,
  input wire o_wready,
  input wire o_bvalid,
  input wire i_bready,
  input wire i_arvalid,
  input wire o_arready,
  input wire [31:0] o_rdata,
  input wire [1:0] o_rresp,
  input wire o_rvalid,
  input wire i_rready
);
  // ======
  // Reads are one at a time, so one held address is enough.
  reg [7:0] ra_reg;
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) ra_reg <= 8'h00;
    else if (i_arvalid && o_arready) ra_reg <= i_araddr;
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  b_answer_a: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
    else $error("write response missing");
  b_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid)
    else $error("write response dropped");
  b_refuse_a: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write taken during response");
  r_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read response missing");
  r_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read response changed");
  r_refuse_a: assert property (o_rvalid |-> !o_arready)
    else $error("read taken during response");
  vec_fields_a: assert property (o_rvalid && ra_reg == `SPSI_OFF_PRIVEC |->
    o_rdata[30:5] == 26'h0 && (!o_rdata[31] || o_rdata[4:0] == 5'h00))
    else $error("vector fields wrong");
  unmapped_a: assert property (o_rvalid && ra_reg[7:2] > 6'h04 |->
    o_rresp == `SPSI_RESP_SLVERR && o_rdata == 32'h0000_0000)
    else $error("unmapped read answered");
endmodule
bind spsi_port_status_irq spsi_props spsi_props_inst (.*);

/* core/spsi_defs.vh */
// Register offsets, field positions and reset values of the port status and interrupt vector block.
`ifndef SPSI_DEFS_VH
`define SPSI_DEFS_VH
// ==========================================================
// Register byte offsets
`define SPSI_OFF_CTRL 8'h00
`define SPSI_OFF_STATUS 8'h04
`define SPSI_OFF_PRIVEC 8'h08
`define SPSI_OFF_IRQSTAT 8'h0c
`define SPSI_OFF_IRQMASK 8'h10
// ==========================================================
// Field positions
`define SPSI_CTRL_IRQEN 13
`define SPSI_ST_REMERR 8
`define SPSI_ST_LOCERR 7
`define SPSI_ST_FIFO_LO 3
`define SPSI_ST_SLAVE_REQUEST_PENDING 2
`define SPSI_ST_MASTER_REQUEST_PENDING 1
`define SPSI_ST_LINK 0
`define SPSI_PV_NONE 31
// ==========================================================
// Reset values
`define SPSI_CTRL_RST 32'h0000_0000
`define SPSI_IRQ_RST 32'h0000_0000
`define SPSI_MASK_RST 32'h0000_0000
`define SPSI_RESP_OKAY 2'h0
`define SPSI_RESP_SLVERR 2'h2
`endif

/* core/spsi_port_status_irq.v */
// Status flags, interrupt status and priority vector logic of a serial bridge port.
// Contract
// - An error symbol arriving on the serial receive path sets the remote error flag, status bit 8.
// - Remote and local error flags are sticky and clear only on a written one to their bit.
// - An error the port's own receive logic finds in an inbound packet sets the local error flag, bit 7.
// - The port interrupt output is high while either error flag is set and control bit 13 is set.
// - Status bits 6 to 3 show non-empty for slave command, slave data, master command, master data FIFOs.
// - Status bit 2 reads one while a request from this port to the peer is outstanding.
// - Status bit 1 reads one while a request from the peer to this port is outstanding.
// - Status bit 0 reads one once link initialisation completed and zero before it or after timeout.
// - Reading the priority vector gives in bits 4-0 the lowest-numbered pending interrupt status bit.
// - Writing the priority vector clears the interrupt status bit selected by written bits 4-0.
// - Priority vector bit 31 reads one when no interrupt status bit is pending, and is one after reset.
// - Priority vector bits 30-5 read zero and ignore writes.
// - The interrupt status register holds unmasked status, clears by written ones, and feeds the encoder.
`timescale 1ns/1ps
`include "spsi_defs.vh"
module spsi_port_status_irq (
  input wire i_ref_clk,
  input wire i_rstn,
  input wire i_remote_error_symbol,
  input wire i_local_rx_error,
  input wire i_slave_cmd_fifo_nonempty,
  input wire i_slave_data_fifo_nonempty,
  input wire i_master_cmd_fifo_nonempty,
  input wire i_master_data_fifo_nonempty,
  input wire i_slave_request_pending,
  input wire i_master_request_pending,
  input wire i_link_up,
  input wire [31:0] i_irq_event,
  input wire [7:0] i_awaddr,
  input wire i_awvalid,
  output wire o_awready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  input wire i_wvalid,
  output wire o_wready,
  output reg [1:0] o_bresp,
  output reg o_bvalid,
  input wire i_bready,
  input wire [7:0] i_araddr,
  input wire i_arvalid,
  output wire o_arready,
  output reg [31:0] o_rdata,
  output reg [1:0] o_rresp,
  output reg o_rvalid,
  input wire i_rready,
  output wire o_port_interrupt_out,
  output wire o_irq
);
  // ==========================================================
  // Input synchronisers: three stages, a change counts when stages two and three agree.
  wire [8:0] async_in;
  reg [8:0] sync1_reg;
  reg [8:0] sync2_reg;
  reg [8:0] sync3_reg;
  reg [8:0] filt_reg;
  reg [8:0] filt_next;
  integer k;
  assign async_in = {i_remote_error_symbol, i_local_rx_error, i_slave_cmd_fifo_nonempty,
                     i_slave_data_fifo_nonempty, i_master_cmd_fifo_nonempty,
                     i_master_data_fifo_nonempty, i_slave_request_pending,
                     i_master_request_pending, i_link_up};
  always @* begin
    filt_next = filt_reg;
    for (k = 0; k < 9; k = k + 1) begin
      if (sync2_reg[k] == sync3_reg[k]) begin
        filt_next[k] = sync3_reg[k];
      end
    end
  end
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1_reg <= 9'h000;
      sync2_reg <= 9'h000;
      sync3_reg <= 9'h000;
      filt_reg <= 9'h000;
    end else begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg <= filt_next;
    end
  end
  // Error inputs are edge-detected so a held error level sets the flag once per assertion.
  reg [1:0] err_prev_reg;
  wire remote_err_evt;
  wire local_err_evt;
  assign remote_err_evt = filt_reg[8] & ~err_prev_reg[1];
  assign local_err_evt = filt_reg[7] & ~err_prev_reg[0];
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      err_prev_reg <= 2'h0;
    end else begin
      err_prev_reg <= filt_reg[8:7];
    end
  end
  // ==========================================================
  // AXI4-Lite write channel: address and data are latched independently, in either order.
  reg aw_full_reg;
  reg w_full_reg;
  reg [7:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  wire wr_go;
  wire wr_hit;
  assign o_awready = ~aw_full_reg & ~o_bvalid;
  assign o_wready = ~w_full_reg & ~o_bvalid;
  assign wr_go = aw_full_reg & w_full_reg & ~o_bvalid;
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp <= `SPSI_RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= i_wdata;
        w_strb_reg <= i_wstrb;
      end
      if (wr_go) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= wr_hit ? `SPSI_RESP_OKAY : `SPSI_RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end
  // ==========================================================
  // Register decode and byte-lane mask.
  wire [31:0] wmask;
  wire [7:0] wa;
  wire wr_ctrl;
  wire wr_stat;
  wire wr_pv;
  wire wr_irq;
  wire wr_mask;
  assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  assign wa = {aw_addr_reg[7:2], 2'b00};
  assign wr_ctrl = wr_go && (wa == `SPSI_OFF_CTRL);
  assign wr_stat = wr_go && (wa == `SPSI_OFF_STATUS);
  assign wr_pv = wr_go && (wa == `SPSI_OFF_PRIVEC);
  assign wr_irq = wr_go && (wa == `SPSI_OFF_IRQSTAT);
  assign wr_mask = wr_go && (wa == `SPSI_OFF_IRQMASK);
  assign wr_hit = wr_ctrl | wr_stat | wr_pv | wr_irq | wr_mask;
  // ==========================================================
  // Control and mask registers.
  reg [31:0] ctrl_reg;
  reg [31:0] mask_reg;
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_reg <= `SPSI_CTRL_RST;
      mask_reg <= `SPSI_MASK_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= (ctrl_reg & ~wmask) | (w_data_reg & wmask);
      end
      if (wr_mask) begin
        mask_reg <= (mask_reg & ~wmask) | (w_data_reg & wmask);
      end
    end
  end
  // ==========================================================
  // Sticky error flags; a new error in the clearing cycle wins over the clear.
  reg remote_error_flag_reg;
  reg local_error_flag_reg;
  wire [31:0] wr_ones;
  assign wr_ones = w_data_reg & wmask;
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      remote_error_flag_reg <= 1'b0;
      local_error_flag_reg <= 1'b0;
    end else begin
      if (remote_err_evt) begin
        remote_error_flag_reg <= 1'b1;
      end else if (wr_stat && wr_ones[`SPSI_ST_REMERR]) begin
        remote_error_flag_reg <= 1'b0;
      end
      if (local_err_evt) begin
        local_error_flag_reg <= 1'b1;
      end else if (wr_stat && wr_ones[`SPSI_ST_LOCERR]) begin
        local_error_flag_reg <= 1'b0;
      end
    end
  end
  assign o_port_interrupt_out = (remote_error_flag_reg | local_error_flag_reg) &
                                ctrl_reg[`SPSI_CTRL_IRQEN];
  wire [31:0] status_word;
  assign status_word = {23'h00_0000, remote_error_flag_reg, local_error_flag_reg,
                        filt_reg[6:3],
                        filt_reg[2],
                        filt_reg[1],
                        filt_reg[0]};
  // ==========================================================
  // Interrupt status: events set sticky bits, written ones or a vector write clear them.
  reg [31:0] irq_stat_reg;
  reg [31:0] irq_clr;
  always @* begin
    irq_clr = 32'h0000_0000;
    if (wr_irq) begin
      irq_clr = wr_ones;
    end
    if (wr_pv && w_strb_reg[0]) begin
      irq_clr = 32'h0000_0001 << w_data_reg[4:0];
    end
  end
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_stat_reg <= `SPSI_IRQ_RST;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | i_irq_event;
    end
  end
  assign o_irq = |(irq_stat_reg & mask_reg);
  // ==========================================================
  // Priority encoder, combinational on the live status so reads after a clear are current.
  reg [4:0] vec;
  integer j;
  always @* begin
    vec = 5'h00;
    for (j = 31; j >= 0; j = j - 1) begin
      if (irq_stat_reg[j]) begin
        vec = j[4:0];
      end
    end
  end
  wire none_pending_flag;
  wire [31:0] privec_word;
  assign none_pending_flag = ~|irq_stat_reg;
  assign privec_word = {none_pending_flag, 26'h000_0000, vec};
  // ==========================================================
  // AXI4-Lite read channel.
  wire [7:0] ra;
  assign ra = {i_araddr[7:2], 2'b00};
  assign o_arready = ~o_rvalid;
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= `SPSI_RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_rvalid <= 1'b1;
      o_rresp <= `SPSI_RESP_OKAY;
      case (ra)
        `SPSI_OFF_CTRL: o_rdata <= ctrl_reg;
        `SPSI_OFF_STATUS: o_rdata <= status_word;
        `SPSI_OFF_PRIVEC: o_rdata <= privec_word;
        `SPSI_OFF_IRQSTAT: o_rdata <= irq_stat_reg;
        `SPSI_OFF_IRQMASK: o_rdata <= mask_reg;
        default: begin
          o_rdata <= 32'h0000_0000;
          o_rresp <= `SPSI_RESP_SLVERR;
        end
      endcase
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
    end
  end
endmodule
